/* hdl/pss_cfg.svh */
// Register map, field positions, reset values, sizes and threshold spacing of the power sequencer.
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PSS_ADDR_CTRL 12'h000
`define PSS_ADDR_BANK 12'h004
`define PSS_ADDR_CLKEN 12'h008
`define PSS_ADDR_PGUARD 12'h00c
`define PSS_ADDR_STATUS 12'h010

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PSS_CTRL_MON_EN 0
`define PSS_CTRL_STBY 1
`define PSS_CTRL_BG_OFF 2
`define PSS_CTRL_RM_OFF 3
`define PSS_CTRL_OSC_SB 4
`define PSS_CTRL_OSC_OFF 5
`define PSS_CTRL_PLL_SB 6
`define PSS_CTRL_PLL_OFF 7
`define PSS_CTRL_WAKE_EN 8
`define PSS_CTRL_W 9

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define PSS_ST_BROWNOUT 8
`define PSS_ST_PWR_LSB 16

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define PSS_CTRL_RST 9'h001
`define PSS_BANK_RST 6'h00
`define PSS_CLKEN_RST 8'hff
`define PSS_PGUARD_RST 32'h00000000
`define PSS_PWR_RST 6'h1b
`define PSS_BANKBUF_RST 6'h3f
`define PSS_IBUF_RST 16'hffff
`define PSS_NUM_BANKS 6
`define PSS_NUM_PCLK 8
`define PSS_NUM_IBUF 16

// ----------------------------------------------------------------------
// Threshold spacing, in tenths of a millivolt
// ----------------------------------------------------------------------
`define PSS_HYST_X10MV 120

`endif

/* hdl/pss_pkg.sv */
// Types shared by the power sequencer modules.
`include "pss_cfg.svh"

package pss_pkg;

  // ----------------------------------------------------------------------
  // Sequencing phases
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PH_POWERUP, PH_LOAD, PH_USER, PH_STANDBY} pss_phase_type;

  // ----------------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pss_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pss_apb_rsp_type;

  // ----------------------------------------------------------------------
  // Supply indications and straps, all from outside the clock domain
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic strap_lowv;
    logic strap_reg;
    logic pll_clk_low;
    logic ext_dn_ok;
    logic core_sram_ok;
    logic core_bg_ok;
    logic ext_up;
    logic cfgbank_up;
    logic core_up;
  } pss_supply_type;

  // ----------------------------------------------------------------------
  // Analog block controls
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pll_clk_gate;
    logic pll_pwr_on;
    logic osc_on;
    logic lpmon_on;
    logic resetmon_on;
    logic bandgap_on;
  } pss_pwr_type;

endpackage

/* hdl/pss_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs.
module pss_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Asynchronous inputs
  input wire logic [WIDTH-1:0] i_async,
  // Synchronised outputs
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } pss_sync_state_type;

  pss_sync_state_type st_r;
  pss_sync_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // A change counts only when the second and third stages agree.
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.out[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.out;

endmodule // pss_sync

/* hdl/pss_top.sv */
// Power-on reset and standby power sequencer with APB register access.
//
// Behaviour
// - Watch core and bank supplies, then load flash.
// - Keep user I/Os tristated before and during load.
// - Release I/Os only after entering user mode.
// - Supervise core supply in user mode when selected.
// - Core below active ramp-down level restarts power-up.
// - Regulated variants also monitor the external supply.
// - Bandgap off disables main monitor; low-power one stays.
// - Bandgap off in standby only on 1.2 V.
// - Reset monitor may be off in standby.
// - Oscillator off statically or on standby entry.
// - PLL powers off only after clocks are low.
// - Per-bank switching of referenced and differential buffers.
// - Independent run-time enable for each primary clock.
// - Input-buffer gate for clock or data paths.
// - Wake and standby outputs only with wake enable.
// - Ramp-down level sits below the ramp-up level.
// - Bank supply has no ramp-down reset check.
//
// The APB interface to the registers and the address map were left to the implementer.
module pss_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB register port
  input wire pss_pkg::pss_apb_req_type i_apb,
  output pss_pkg::pss_apb_rsp_type o_apb,
  // Supply comparators, PLL status and variant straps
  input wire pss_pkg::pss_supply_type i_supply,
  // Configuration flash
  input wire logic i_flash_done,
  output logic o_flash_start,
  // Core user logic
  output logic o_user_reset_n,
  output logic o_io_release,
  // Two-wire core requests and gated outputs to the power module
  input wire logic i_tw_wake,
  input wire logic i_tw_stdby,
  output logic o_tw_wake,
  output logic o_tw_stdby,
  // Analog power controls
  output pss_pkg::pss_pwr_type o_pwr,
  // Buffer and clock gating
  output logic [`PSS_NUM_BANKS-1:0] o_bank_buf_on,
  output logic [`PSS_NUM_PCLK-1:0] o_pclk_en,
  output logic [`PSS_NUM_IBUF-1:0] o_ibuf_on
);

  import pss_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pss_phase_type phase;
    logic [`PSS_CTRL_W-1:0] ctrl;
    logic [`PSS_NUM_BANKS-1:0] bank_off;
    logic [`PSS_NUM_PCLK-1:0] clk_en;
    logic [31:0] pguard;
    logic brownout;
    logic variant_reg;
    logic variant_lowv;
    logic tw_stby;
    logic flash_start;
    logic user_reset_n;
    logic io_release;
    logic tw_wake_out;
    logic tw_stdby_out;
    pss_pwr_type pwr;
    logic [`PSS_NUM_BANKS-1:0] bank_buf_on;
    logic [`PSS_NUM_PCLK-1:0] pclk_en;
    logic [`PSS_NUM_IBUF-1:0] ibuf_on;
    pss_apb_rsp_type apb;
  } pss_state_type;

  pss_state_type st_r;
  pss_state_type st_nxt;
  pss_supply_type sup;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic pss_addr_hit(input logic [11:0] addr);
    pss_addr_hit = (addr == `PSS_ADDR_CTRL) || (addr == `PSS_ADDR_BANK) ||
                   (addr == `PSS_ADDR_CLKEN) || (addr == `PSS_ADDR_PGUARD) ||
                   (addr == `PSS_ADDR_STATUS);
  endfunction

  function automatic logic pss_is_live(input pss_phase_type ph);
    pss_is_live = (ph == PH_USER) || (ph == PH_STANDBY);
  endfunction

  function automatic logic pss_bo_clear(input pss_apb_req_type req, input logic wr_ok);
    pss_bo_clear = wr_ok && (req.paddr == `PSS_ADDR_STATUS) && req.pwdata[`PSS_ST_BROWNOUT];
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  pss_sync #(
    .WIDTH($bits(pss_supply_type))
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_supply),
    .o_sync(sup)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic access;
  logic wr;
  logic live;
  logic standby;
  logic stby_want;
  logic supplies_up;
  logic main_mon;
  logic bo_event;
  logic pll_want_off;
  logic [31:0] rd_data;

  always_comb
  begin
    st_nxt = st_r;
    live = pss_is_live(st_r.phase);
    standby = (st_r.phase == PH_STANDBY);

    // ----------------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------------
    // Register access: one wait state, the write lands on the completing edge.
    access = i_apb.psel & i_apb.penable;
    wr = access & st_r.apb.pready & i_apb.pwrite & pss_addr_hit(i_apb.paddr);
    rd_data = 32'h00000000;
    unique case (i_apb.paddr)
      `PSS_ADDR_CTRL: rd_data[`PSS_CTRL_W-1:0] = st_r.ctrl;
      `PSS_ADDR_BANK: rd_data[`PSS_NUM_BANKS-1:0] = st_r.bank_off;
      `PSS_ADDR_CLKEN: rd_data[`PSS_NUM_PCLK-1:0] = st_r.clk_en;
      `PSS_ADDR_PGUARD: rd_data = st_r.pguard;
      `PSS_ADDR_STATUS:
      begin
        rd_data[1:0] = st_r.phase;
        rd_data[2] = st_r.variant_reg;
        rd_data[3] = st_r.variant_lowv;
        rd_data[4] = st_r.tw_stby;
        rd_data[`PSS_ST_BROWNOUT] = st_r.brownout;
        rd_data[`PSS_ST_PWR_LSB +: $bits(pss_pwr_type)] = st_r.pwr;
      end
      default: rd_data = 32'h00000000;
    endcase
    // A master that leaves penable high after the answer would get a second pulse.
    if (access && !st_r.apb.pready)
    begin
      st_nxt.apb.pready = 1'b1;
      st_nxt.apb.pslverr = !pss_addr_hit(i_apb.paddr);
      st_nxt.apb.prdata = i_apb.pwrite ? 32'h00000000 : rd_data;
    end
    else
    begin
      st_nxt.apb.pready = 1'b0;
      st_nxt.apb.pslverr = 1'b0;
    end
    if (wr)
    begin
      unique case (i_apb.paddr)
        `PSS_ADDR_CTRL: st_nxt.ctrl = i_apb.pwdata[`PSS_CTRL_W-1:0];
        `PSS_ADDR_BANK: st_nxt.bank_off = i_apb.pwdata[`PSS_NUM_BANKS-1:0];
        `PSS_ADDR_CLKEN: st_nxt.clk_en = i_apb.pwdata[`PSS_NUM_PCLK-1:0];
        `PSS_ADDR_PGUARD: st_nxt.pguard = i_apb.pwdata;
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    // ----------------------------------------------------------------------
    // Two-wire requests
    // ----------------------------------------------------------------------
    // Two-wire standby requests are honoured only with wake enable set.
    st_nxt.tw_wake_out = st_r.ctrl[`PSS_CTRL_WAKE_EN] & i_tw_wake;
    st_nxt.tw_stdby_out = st_r.ctrl[`PSS_CTRL_WAKE_EN] & i_tw_stdby;
    if (!st_r.ctrl[`PSS_CTRL_WAKE_EN])
    begin
      st_nxt.tw_stby = 1'b0;
    end
    else if (i_tw_stdby)
    begin
      st_nxt.tw_stby = 1'b1;
    end
    else if (i_tw_wake)
    begin
      st_nxt.tw_stby = 1'b0;
    end
    stby_want = st_r.ctrl[`PSS_CTRL_STBY] | st_r.tw_stby;

    // ----------------------------------------------------------------------
    // Supervision
    // ----------------------------------------------------------------------
    // Ramp-up needs core and bank supplies, plus the external one on regulated variants; the bank supply is never checked again.
    supplies_up = sup.core_up & sup.cfgbank_up & (!st_r.variant_reg | sup.ext_up);

    // The main monitor trips on the lower bandgap level, so a supply that
    // just passed ramp-up cannot bounce straight back into reset.
    main_mon = st_r.ctrl[`PSS_CTRL_MON_EN] & st_r.pwr.resetmon_on;
    bo_event = live &&
               ((main_mon && (!sup.core_bg_ok || (st_r.variant_reg && !sup.ext_dn_ok))) ||
                (st_r.pwr.lpmon_on && !sup.core_sram_ok));

    // A new event wins over a clear written in the same cycle.
    st_nxt.brownout = (st_r.brownout & !pss_bo_clear(i_apb, wr)) | bo_event;

    // ----------------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------------
    unique case (st_r.phase)
      PH_POWERUP:
      begin
        // Straps are followed only here, so a strap glitch in user mode changes nothing.
        st_nxt.variant_reg = sup.strap_reg;
        st_nxt.variant_lowv = sup.strap_lowv;
        st_nxt.user_reset_n = 1'b0;
        st_nxt.io_release = 1'b0;
        if (supplies_up)
        begin
          st_nxt.phase = PH_LOAD;
          st_nxt.flash_start = 1'b1;
        end
      end
      PH_LOAD:
      begin
        if (!sup.core_bg_ok)
        begin
          st_nxt.phase = PH_POWERUP;
          st_nxt.flash_start = 1'b0;
        end
        else if (i_flash_done)
        begin
          st_nxt.phase = PH_USER;
          st_nxt.flash_start = 1'b0;
          st_nxt.user_reset_n = 1'b1;
          st_nxt.io_release = 1'b1;
        end
      end
      PH_USER:
      begin
        if (stby_want)
        begin
          st_nxt.phase = PH_STANDBY;
        end
      end
      PH_STANDBY:
      begin
        if (!stby_want)
        begin
          st_nxt.phase = PH_USER;
        end
      end
    endcase
    if (bo_event)
    begin
      st_nxt.phase = PH_POWERUP;
      st_nxt.user_reset_n = 1'b0;
      st_nxt.io_release = 1'b0;
      st_nxt.flash_start = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Power controls
    // ----------------------------------------------------------------------
    // Analog power controls, following the phase just entered.
    standby = (st_nxt.phase == PH_STANDBY);
    st_nxt.pwr.bandgap_on = !(standby && st_r.ctrl[`PSS_CTRL_BG_OFF] && st_r.variant_lowv);
    st_nxt.pwr.resetmon_on = st_nxt.pwr.bandgap_on &&
                             !(standby && st_r.ctrl[`PSS_CTRL_RM_OFF]);
    st_nxt.pwr.lpmon_on = !st_nxt.pwr.resetmon_on;
    st_nxt.pwr.osc_on = st_nxt.pwr.bandgap_on && !st_r.ctrl[`PSS_CTRL_OSC_OFF] &&
                        !(standby && st_r.ctrl[`PSS_CTRL_OSC_SB]);

    // The PLL is gated first and loses power only once its clocks read low.
    pll_want_off = st_r.ctrl[`PSS_CTRL_PLL_OFF] || (standby && st_r.ctrl[`PSS_CTRL_PLL_SB]) ||
                   !st_nxt.pwr.bandgap_on;
    if (pll_want_off)
    begin
      st_nxt.pwr.pll_clk_gate = 1'b1;
      if (st_r.pwr.pll_clk_gate && sup.pll_clk_low)
      begin
        st_nxt.pwr.pll_pwr_on = 1'b0;
      end
    end
    else
    begin
      st_nxt.pwr.pll_pwr_on = 1'b1;
      if (st_r.pwr.pll_pwr_on)
      begin
        st_nxt.pwr.pll_clk_gate = 1'b0;
      end
    end

    // Referenced and differential buffers also need the bandgap.
    st_nxt.bank_buf_on = ~st_nxt.bank_off & {`PSS_NUM_BANKS{st_nxt.pwr.bandgap_on}};
    st_nxt.pclk_en = st_nxt.clk_en;
    st_nxt.ibuf_on = ~(st_nxt.pguard[`PSS_NUM_IBUF-1:0] |
                       (st_nxt.pguard[31:16] & {`PSS_NUM_IBUF{standby}}));
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
      st_r.phase <= PH_POWERUP;
      st_r.ctrl <= `PSS_CTRL_RST;
      st_r.bank_off <= `PSS_BANK_RST;
      st_r.clk_en <= `PSS_CLKEN_RST;
      st_r.pguard <= `PSS_PGUARD_RST;
      st_r.pwr <= `PSS_PWR_RST;
      st_r.pclk_en <= `PSS_CLKEN_RST;
      st_r.ibuf_on <= `PSS_IBUF_RST;
      st_r.bank_buf_on <= `PSS_BANKBUF_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_apb = st_r.apb;
  assign o_flash_start = st_r.flash_start;
  assign o_user_reset_n = st_r.user_reset_n;
  assign o_io_release = st_r.io_release;
  assign o_tw_wake = st_r.tw_wake_out;
  assign o_tw_stdby = st_r.tw_stdby_out;
  assign o_pwr = st_r.pwr;
  assign o_bank_buf_on = st_r.bank_buf_on;
  assign o_pclk_en = st_r.pclk_en;
  assign o_ibuf_on = st_r.ibuf_on;

endmodule // pss_top

/* test/pss_assertions.sv */
// Concurrent checks on the power sequencer ports.
`include "pss_cfg.svh"
module pss_assertions
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Bus and inputs
  input wire pss_apb_req_type i_apb,
  input wire pss_apb_rsp_type o_apb,
  input wire pss_supply_type i_supply,
  input wire logic i_flash_done,
  input wire logic i_tw_wake,
  input wire logic i_tw_stdby,
  // Outputs
  input wire logic o_flash_start,
  input wire logic o_user_reset_n,
  input wire logic o_io_release,
  input wire logic o_tw_wake,
  input wire logic o_tw_stdby,
  input wire pss_pwr_type o_pwr,
  input wire logic [`PSS_NUM_BANKS-1:0] o_bank_buf_on,
  input wire logic [`PSS_NUM_PCLK-1:0] o_pclk_en,
  input wire logic [`PSS_NUM_IBUF-1:0] o_ibuf_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ----
  // Checks
  // ----
  AST_IO_HELD: assert property ((o_flash_start || !o_user_reset_n) |-> !o_io_release)
    else $error("io released during reset or load");
  AST_IO_AFTER_LOAD: assert property ($rose(o_io_release) |-> $past(o_flash_start && i_flash_done))
    else $error("io released without finished load");
  AST_LOAD_SUPPLY: assert property ($rose(o_flash_start) |->
    $past(i_supply.core_up & i_supply.cfgbank_up & (i_supply.ext_up | !i_supply.strap_reg), 3))
    else $error("load started without good supplies");
  AST_RESET_FALL: assert property ($fell(o_user_reset_n) |-> !o_io_release && !o_flash_start)
    else $error("reset without return to power-up");
  AST_LPMON_TRIP: assert property ((o_io_release && o_pwr.lpmon_on && !i_supply.core_sram_ok) [*5]
    |-> ##[0:2] !o_user_reset_n)
    else $error("low-power monitor missed a drop");
  AST_BG_OFF_ALL: assert property (!o_pwr.bandgap_on |-> !o_pwr.resetmon_on && !o_pwr.osc_on
    && o_pwr.lpmon_on && (o_bank_buf_on == '0))
    else $error("bandgap off left analog blocks on");
  AST_BG_OFF_WHEN: assert property ($fell(o_pwr.bandgap_on) |-> o_user_reset_n && i_supply.strap_lowv)
    else $error("bandgap off outside low-voltage user mode");
  AST_PLL_OFF: assert property ($fell(o_pwr.pll_pwr_on) |-> $past(o_pwr.pll_clk_gate)
    && $past(i_supply.pll_clk_low, 2))
    else $error("pll off before clocks low");
  AST_PLL_ON: assert property ($rose(o_pwr.pll_pwr_on) |-> o_pwr.pll_clk_gate ##1 !o_pwr.pll_clk_gate)
    else $error("pll clock gate order wrong");
  AST_TW_GATED: assert property (({o_tw_wake, o_tw_stdby} & ~$past({i_tw_wake, i_tw_stdby})) == 2'b00)
    else $error("two-wire output without request");
  // ----
  // Coverage
  // ----
  cover property ($rose(o_io_release));
  cover property ($fell(o_pwr.pll_pwr_on));
  cover property ($fell(o_user_reset_n));
  cover property (o_apb.pready && o_apb.pslverr);
endmodule // pss_assertions

bind pss_top pss_assertions i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(i_apb), .o_apb(o_apb),
  .i_supply(i_supply), .i_flash_done(i_flash_done), .i_tw_wake(i_tw_wake), .i_tw_stdby(i_tw_stdby),
  .o_flash_start(o_flash_start), .o_user_reset_n(o_user_reset_n), .o_io_release(o_io_release),
  .o_tw_wake(o_tw_wake), .o_tw_stdby(o_tw_stdby), .o_pwr(o_pwr), .o_bank_buf_on(o_bank_buf_on),
  .o_pclk_en(o_pclk_en), .o_ibuf_on(o_ibuf_on));

/* test/pss_flash_model.sv */
// Behavioural configuration flash that answers a download request.
module pss_flash_model #(
  parameter int LOAD_CYC = 12
) (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_slow,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r = 0;
  initial o_done = 1'b0;
  // Done is held only while the request stands, so a restart always waits a full load.
  always @(posedge i_clk)
  begin
    if (!i_start)
    begin
      cnt_r <= 0;
      o_done <= 1'b0;
    end
    else if (cnt_r < (i_slow ? 4 * LOAD_CYC : LOAD_CYC))
      cnt_r <= cnt_r + 1;
    else
      o_done <= 1'b1;
  end
endmodule // pss_flash_model

/* test/pss_top_tb.sv */
// Self-checking testbench of the power sequencer.
module pss_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_tw_wake = 0, i_tw_stdby = 0, slow = 0, err;
  logic flash_done, flash_start, user_rst_n, io_rel, tw_wake, tw_stdby;
  pss_apb_req_type req = '0;
  pss_apb_rsp_type rsp;
  pss_supply_type sup = 9'h180;
  pss_pwr_type pwr;
  logic [5:0] bank;
  logic [7:0] pclk;
  logic [15:0] ibuf;
  logic [31:0] rd;
  logic [31:0] rv [4] = '{32'h1, 32'h0, 32'hff, 32'h0};
  int failures = 0, checked = 0;

  pss_top i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(req), .o_apb(rsp), .i_supply(sup),
    .i_flash_done(flash_done), .o_flash_start(flash_start), .o_user_reset_n(user_rst_n),
    .o_io_release(io_rel), .i_tw_wake(i_tw_wake), .i_tw_stdby(i_tw_stdby), .o_tw_wake(tw_wake),
    .o_tw_stdby(tw_stdby), .o_pwr(pwr), .o_bank_buf_on(bank), .o_pclk_en(pclk), .o_ibuf_on(ibuf));
  pss_flash_model i_flash (.i_clk(i_clk), .i_start(flash_start), .i_slow(slow), .o_done(flash_done));

  initial forever #5 i_clk = ~i_clk;
  initial
  begin
    #300000;
    failures++;
    report_and_stop();
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // A master that assumes no wait-state count: it holds the access until pready, giving up after 50 cycles.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    // Pready is looked at mid-cycle, where it is settled; the access ends at the next rising edge.
    @(negedge i_clk);
    while (rsp.pready !== 1'b1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    if (rsp.pready !== 1'b1)
      failures++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    @(posedge i_clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wt(input logic v);
    for (int n = 0; n < 300 && io_rel !== v; n++) @(posedge i_clk);
    if (io_rel !== v)
      failures++;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    cyc(2);
    chk({io_rel, user_rst_n, flash_start, pwr, bank, pclk, ibuf}, {3'b000, 6'h1b, 6'h3f, 8'hff, 16'hffff});
    i_reset_n <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(rd, rv[k]);
    end
    sup <= 9'h1fb;
    cyc(20);
    chk({flash_start, io_rel}, 2'b00);
    sup <= 9'h1ff;
    for (int n = 0; n < 20 && flash_start !== 1'b1; n++) @(posedge i_clk);
    chk({flash_start, io_rel}, 2'b10);
    wt(1'b1);
    chk({io_rel, user_rst_n, flash_start}, 3'b110);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[3:0], 4'he);
    $display("Power-up test done");
    apb(1'b1, 12'h004, 32'h15);
    apb(1'b1, 12'h008, 32'h5a);
    apb(1'b1, 12'h00c, 32'h00f0000f);
    cyc(3);
    chk({bank, pclk, ibuf}, {~6'h15, 8'h5a, ~16'h000f});
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("Register test done");
    sup.pll_clk_low <= 1'b0;
    apb(1'b1, 12'h000, 32'h57);
    cyc(8);
    chk(pwr[5:4], 2'b11);
    chk({pwr[3:0], bank, ibuf}, {4'h4, 6'h00, ~16'h00ff});
    sup.pll_clk_low <= 1'b1;
    cyc(8);
    chk(pwr.pll_pwr_on, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    cyc(6);
    chk({pwr, bank}, {6'h1b, ~6'h15});
    apb(1'b1, 12'h000, 32'ha1);
    cyc(8);
    chk({pwr.pll_pwr_on, pwr.osc_on}, 2'b00);
    apb(1'b1, 12'h000, 32'h0b);
    cyc(8);
    chk({pwr.lpmon_on, pwr.resetmon_on, pwr.bandgap_on}, 3'b101);
    sup.core_sram_ok <= 1'b0;
    wt(1'b0);
    chk({user_rst_n, io_rel}, 2'b00);
    apb(1'b1, 12'h000, 32'h1);
    sup <= 9'h1ff;
    wt(1'b1);
    apb(1'b1, 12'h010, 32'h100);
    $display("Standby test done");
    i_tw_stdby <= 1'b1;
    cyc(3);
    chk({tw_wake, tw_stdby}, 2'b00);
    apb(1'b1, 12'h000, 32'h101);
    cyc(3);
    apb(1'b0, 12'h010, 32'h0);
    chk({tw_stdby, rd[4], rd[1:0]}, 4'hf);
    i_tw_stdby <= 1'b0;
    i_tw_wake <= 1'b1;
    cyc(3);
    apb(1'b0, 12'h010, 32'h0);
    chk({tw_wake, tw_stdby, rd[1:0]}, 4'ha);
    i_tw_wake <= 1'b0;
    $display("Two-wire test done");
    apb(1'b1, 12'h000, 32'h0);
    sup.core_bg_ok <= 1'b0;
    sup.cfgbank_up <= 1'b0;
    cyc(10);
    chk({user_rst_n, io_rel}, 2'b11);
    apb(1'b1, 12'h000, 32'h1);
    wt(1'b0);
    chk({user_rst_n, io_rel}, 2'b00);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[8], 1'b1);
    sup <= 9'h1ff;
    slow <= 1'b1;
    apb(1'b1, 12'h010, 32'h100);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[8], 1'b0);
    wt(1'b1);
    chk({io_rel, user_rst_n}, 2'b11);
    $display("Brown-out test done");
    report_and_stop();
  end
endmodule // pss_top_tb
